//--- cmd_status_pkg.sv
// Constants and helpers for the per-function command and status registers
// Functional notes
// - Each of the two functions has its own command register, no shared enable bits.
// - Effective system-error and parity-response enables are the OR over both functions.
// - Command bits 15 to 10 read zero and ignore writes.
// - Command bit 9 reads zero; no fast back-to-back transactions are generated.
// - Command bit 8 gates the SERR driver; clear in both functions means SERR is never driven.
// - Address parity errors reach SERR only with command bits 8 and 6 both set.
// - Command bit 7 reads zero, ignores writes; no address or data stepping.
// - Bit 6 set: data parity errors on PERR, address errors on SERR if bit 8 is also set; clear in both functions ignores.
// - Command bit 5 reads zero, ignores writes; palette accesses are not snooped.
// - Command bit 4 reads zero; plain memory writes only, never write-and-invalidate.
// - Command bit 3 reads zero, ignores writes; special cycles are not answered.
// - Initiator accesses only while command bit 2 is set; resets to zero.
// - Memory-space cycles claimed only while command bit 1 is set; resets to zero.
// - I/O-space cycles claimed only while command bit 0 is set; resets to zero.
// - Writing one clears a clearable status bit; writing zero leaves it alone.
// - Each function shows bus status in its own status register.
// - Status bit 15 sets on any address parity error or a data parity error of its own function; write one clears.
// - Status bit 8 sets on PERR while master with parity response enabled.
// - Status bits 10 to 9 read fixed binary 01, medium select timing.
// - Status bit 13 sets when an initiated cycle ends in master abort.
`default_nettype none
package cmd_status_pkg;
  localparam int NUM_FUNC = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Command and status share one configuration dword
  localparam logic [ADDR_W-1:0] CMD_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 8'h06;
  localparam int DWORD_LSB = 2;
  // Command bit positions
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_PARITY_RESP_BIT = 6;
  localparam int CMD_SYS_ERR_BIT = 8;
  localparam logic [REG_W-1:0] CMD_WRITE_MASK = 16'h0147;
  localparam logic [REG_W-1:0] CMD_RESET = 16'h0000;
  // Status bit positions
  localparam int STAT_PARITY_DET_BIT = 15;
  localparam int STAT_SIG_SYS_ERR_BIT = 14;
  localparam int STAT_MASTER_ABORT_BIT = 13;
  localparam int STAT_TABORT_RCVD_BIT = 12;
  localparam int STAT_TABORT_SIG_BIT = 11;
  localparam int STAT_MASTER_PARITY_BIT = 8;
  localparam logic [REG_W-1:0] STAT_CLEAR_MASK = 16'hF900;
  localparam logic [REG_W-1:0] STAT_FIXED = 16'h0210;
  localparam logic [1:0] STAT_SPEED_MEDIUM = 2'h1;
  localparam int STAT_SPEED_LSB = 9;
  localparam int STAT_CAP_LIST_BIT = 4;

  // Byte-lane merge of a 16-bit half under two byte enables
  function automatic logic [REG_W-1:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage : cmd_status_pkg
`default_nettype wire

//--- status_flags.sv
// Sticky write-one-to-clear status register for one function
`default_nettype none
module status_flags (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [cmd_status_pkg::REG_W-1:0] i_set,
  input wire logic [cmd_status_pkg::REG_W-1:0] i_clr,
  output logic [cmd_status_pkg::REG_W-1:0] o_flags
);
  import cmd_status_pkg::*;

  logic [REG_W-1:0] flags_q;
  logic [REG_W-1:0] flags_d;

  // Set beats clear so an event in the clearing cycle is not lost
  assign flags_d = ((flags_q & ~(i_clr & STAT_CLEAR_MASK)) | (i_set & STAT_CLEAR_MASK))
                   | STAT_FIXED;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flags_q <= STAT_FIXED;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

  a_set_beats_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_set[STAT_PARITY_DET_BIT] && i_clr[STAT_PARITY_DET_BIT]) |=> flags_q[STAT_PARITY_DET_BIT])
    else $error("status set lost to coinciding clear");
  a_clear_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_clr[STAT_MASTER_ABORT_BIT] && !i_set[STAT_MASTER_ABORT_BIT]) |=> !flags_q[STAT_MASTER_ABORT_BIT])
    else $error("write of one did not clear status bit");
  a_hold_until_clr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (flags_q[STAT_TABORT_SIG_BIT] && !i_clr[STAT_TABORT_SIG_BIT]) |=> flags_q[STAT_TABORT_SIG_BIT])
    else $error("status bit dropped without a clear");
endmodule // status_flags
`default_nettype wire

//--- cmd_status_regs.sv
// Two-function command and status configuration registers with bus enables
`default_nettype none
module cmd_status_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Configuration access
  input wire logic i_cfg_func,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [cmd_status_pkg::ADDR_W-1:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [cmd_status_pkg::DATA_W-1:0] i_cfg_wdata,
  output logic [cmd_status_pkg::DATA_W-1:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Bus events from the datapaths
  input wire logic i_addr_parity_error_detected,
  input wire logic [cmd_status_pkg::NUM_FUNC-1:0] i_data_parity_error_detected,
  input wire logic [cmd_status_pkg::NUM_FUNC-1:0] i_perr_as_master,
  input wire logic [cmd_status_pkg::NUM_FUNC-1:0] i_master_abort,
  input wire logic [cmd_status_pkg::NUM_FUNC-1:0] i_target_abort_rcvd,
  input wire logic [cmd_status_pkg::NUM_FUNC-1:0] i_target_abort_sig,
  // Enables to the datapaths
  output logic [cmd_status_pkg::NUM_FUNC-1:0] o_io_enable,
  output logic [cmd_status_pkg::NUM_FUNC-1:0] o_mem_enable,
  output logic [cmd_status_pkg::NUM_FUNC-1:0] o_bus_master_enable,
  output logic o_parity_response_enable,
  output logic o_system_error_enable,
  output logic o_write_invalidate_enable,
  output logic o_back_to_back_enable,
  // Error pins, open drain
  output logic o_perr_n,
  output logic o_perr_oe,
  output logic o_serr_n,
  output logic o_serr_oe
);
  import cmd_status_pkg::*;

  logic [REG_W-1:0] cmd_q [NUM_FUNC];
  logic [REG_W-1:0] cmd_d [NUM_FUNC];
  logic [REG_W-1:0] stat_w [NUM_FUNC];
  logic [REG_W-1:0] stat_set [NUM_FUNC];
  logic [REG_W-1:0] stat_clr [NUM_FUNC];
  logic [NUM_FUNC-1:0] cmd_wr;
  logic [NUM_FUNC-1:0] stat_wr;
  logic [NUM_FUNC-1:0] sys_err_bits;
  logic [NUM_FUNC-1:0] parity_bits;
  logic dword_hit;
  logic parity_eff;
  logic sys_err_eff;
  logic serr_fire;
  logic perr_fire;
  logic serr_q;
  logic perr_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic [REG_W-1:0] cmd_wmask;
  logic [REG_W-1:0] stat_wmask;

  // Address decode: command and status live in one dword
  assign dword_hit = (i_cfg_addr[ADDR_W-1:DWORD_LSB] == CMD_OFFSET[ADDR_W-1:DWORD_LSB]);
  assign cmd_wmask = lane_mask(i_cfg_be[1:0]) & CMD_WRITE_MASK;
  assign stat_wmask = lane_mask(i_cfg_be[3:2]);

  // Wired-OR of the per-function error enables
  assign parity_eff = |parity_bits;
  assign sys_err_eff = |sys_err_bits;

  // SERR only for address parity with both enables; PERR only with parity response
  assign serr_fire = i_addr_parity_error_detected && sys_err_eff && parity_eff;
  assign perr_fire = (|i_data_parity_error_detected) && parity_eff;

  genvar f;
  generate
    for (f = 0; f < NUM_FUNC; f++) begin : g_func
      // Each function decodes its own write, so no enable bit is shared
      assign cmd_wr[f] = i_cfg_wr && dword_hit && (i_cfg_func == 1'(f));
      assign stat_wr[f] = cmd_wr[f];

      // Only the writable bits take new data; all others stay zero
      assign cmd_d[f] = cmd_wr[f] ? ((cmd_q[f] & ~cmd_wmask) | (i_cfg_wdata[REG_W-1:0] & cmd_wmask))
                                  : cmd_q[f];

      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          cmd_q[f] <= CMD_RESET;
        end else begin
          cmd_q[f] <= cmd_d[f];
        end
      end

      assign sys_err_bits[f] = cmd_q[f][CMD_SYS_ERR_BIT];
      assign parity_bits[f] = cmd_q[f][CMD_PARITY_RESP_BIT];

      // Enables seen by the datapaths follow the function's own bits
      assign o_io_enable[f] = cmd_q[f][CMD_IO_BIT];
      assign o_mem_enable[f] = cmd_q[f][CMD_MEM_BIT];
      assign o_bus_master_enable[f] = cmd_q[f][CMD_MASTER_BIT];

      // Status events for this function
      always_comb begin
        stat_set[f] = '0;
        stat_set[f][STAT_PARITY_DET_BIT] = i_addr_parity_error_detected || i_data_parity_error_detected[f];
        stat_set[f][STAT_SIG_SYS_ERR_BIT] = serr_fire;
        stat_set[f][STAT_MASTER_ABORT_BIT] = i_master_abort[f] && o_bus_master_enable[f];
        stat_set[f][STAT_TABORT_RCVD_BIT] = i_target_abort_rcvd[f] && o_bus_master_enable[f];
        stat_set[f][STAT_TABORT_SIG_BIT] = i_target_abort_sig[f];
        stat_set[f][STAT_MASTER_PARITY_BIT] = i_perr_as_master[f] && parity_eff
                                              && o_bus_master_enable[f];
      end

      assign stat_clr[f] = stat_wr[f] ? (i_cfg_wdata[DATA_W-1:REG_W] & stat_wmask) : '0;

      status_flags u_status (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(stat_set[f]),
        .i_clr(stat_clr[f]),
        .o_flags(stat_w[f])
      );
    end
  endgenerate

  assign o_parity_response_enable = parity_eff;
  assign o_system_error_enable = sys_err_eff;
  // Write-and-invalidate and fast back-to-back are never generated
  assign o_write_invalidate_enable = 1'b0;
  assign o_back_to_back_enable = 1'b0;

  // Read path: the selected function's dword, zero elsewhere
  assign rdata_d = dword_hit ? {stat_w[i_cfg_func], cmd_q[i_cfg_func]} : '0;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= i_cfg_rd ? rdata_d : rdata_q;
      rvalid_q <= i_cfg_rd;
    end
  end

  assign o_cfg_rdata = rdata_q;
  assign o_cfg_rvalid = rvalid_q;

  // Error pin drivers: one-cycle assertion per detected error
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      serr_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      serr_q <= serr_fire;
      perr_q <= perr_fire;
    end
  end

  // Pins only ever pull low, released otherwise
  assign o_serr_oe = serr_q;
  assign o_serr_n = ~serr_q;
  assign o_perr_oe = perr_q;
  assign o_perr_n = ~perr_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_cmd_reserved_zero: assert property (
    ((cmd_q[0] | cmd_q[1]) & ~CMD_WRITE_MASK) == 16'h0000)
    else $error("command read-only bits not zero");

  a_cmd_fixed_zero: assert property (
    !cmd_q[0][7] && !cmd_q[0][9] && !cmd_q[0][5] && !cmd_q[0][4] && !cmd_q[0][3])
    else $error("command hardwired bit became set");

  a_cmd_write_f0: assert property (
    (cmd_wr[0] && i_cfg_be[0] && i_cfg_be[1])
    |=> (cmd_q[0] == ($past(i_cfg_wdata[REG_W-1:0]) & CMD_WRITE_MASK)) && $stable(cmd_q[1]))
    else $error("function 0 command write wrong or leaked");

  a_cmd_write_f1: assert property (
    (cmd_wr[1] && i_cfg_be[0] && i_cfg_be[1])
    |=> (cmd_q[1] == ($past(i_cfg_wdata[REG_W-1:0]) & CMD_WRITE_MASK)) && $stable(cmd_q[0]))
    else $error("function 1 command write wrong or leaked");

  a_enable_wired_or: assert property (
    (o_system_error_enable == (cmd_q[0][CMD_SYS_ERR_BIT] || cmd_q[1][CMD_SYS_ERR_BIT]))
    && (o_parity_response_enable == (cmd_q[0][CMD_PARITY_RESP_BIT] || cmd_q[1][CMD_PARITY_RESP_BIT])))
    else $error("effective enable is not the OR of both functions");

  a_serr_needs_both: assert property (
    o_serr_oe |-> $past(i_addr_parity_error_detected && sys_err_eff && parity_eff))
    else $error("SERR driven without both enables and an address error");

  a_serr_on_addr: assert property (
    (i_addr_parity_error_detected && sys_err_eff && parity_eff) |=> (o_serr_oe && !o_serr_n))
    else $error("SERR not driven on enabled address parity error");

  a_perr_gated: assert property (
    o_perr_oe |-> $past(parity_eff && (|i_data_parity_error_detected)))
    else $error("PERR driven without parity response");

  a_master_gate: assert property (
    o_bus_master_enable == {cmd_q[1][CMD_MASTER_BIT], cmd_q[0][CMD_MASTER_BIT]})
    else $error("master enable not tied to command bit 2");

  a_space_gate: assert property (
    (o_mem_enable[0] == cmd_q[0][CMD_MEM_BIT]) && (o_io_enable[1] == cmd_q[1][CMD_IO_BIT]))
    else $error("space enables not tied to command bits");

  a_parity_status: assert property (
    i_addr_parity_error_detected |=> stat_w[0][STAT_PARITY_DET_BIT] && stat_w[1][STAT_PARITY_DET_BIT])
    else $error("address parity error not recorded in both functions");

  a_master_par_cause: assert property (
    $rose(stat_w[0][STAT_MASTER_PARITY_BIT])
    |-> $past(i_perr_as_master[0] && parity_eff && o_bus_master_enable[0]))
    else $error("master parity flag set without its conditions");

  a_abort_status: assert property (
    (i_master_abort[1] && o_bus_master_enable[1]) |=> stat_w[1][STAT_MASTER_ABORT_BIT])
    else $error("master abort not recorded");

  a_speed_fixed: assert property (
    (stat_w[0][STAT_SPEED_LSB +: 2] == STAT_SPEED_MEDIUM) && stat_w[1][STAT_CAP_LIST_BIT])
    else $error("fixed status bits wrong");

  a_reset_defaults: assert property (
    $past(i_rst) |-> (cmd_q[0] == CMD_RESET) && (cmd_q[1] == CMD_RESET)
    && (stat_w[0] == STAT_FIXED) && (stat_w[1] == STAT_FIXED))
    else $error("registers not at defaults after reset");

  a_read_timing: assert property (
    (i_cfg_rd && dword_hit && !i_cfg_func)
    |=> o_cfg_rvalid && (o_cfg_rdata[REG_W-1:0] == $past(cmd_q[0])))
    else $error("read answer late or wrong");

  a_rvalid_single: assert property (
    !i_cfg_rd
    |=> !o_cfg_rvalid)
    else $error("read valid without a read");

  a_rdata_holds: assert property (
    !i_cfg_rd
    |=> $stable(o_cfg_rdata))
    else $error("read data changed without a read");

  a_miss_reads_zero: assert property (
    (i_cfg_rd && !dword_hit)
    |=> (o_cfg_rdata == '0))
    else $error("read outside the register dword not zero");

  a_io_gate: assert property (
    o_io_enable == {cmd_q[1][CMD_IO_BIT], cmd_q[0][CMD_IO_BIT]})
    else $error("io enables not tied to command bit 0");

  a_mem_gate: assert property (
    o_mem_enable == {cmd_q[1][CMD_MEM_BIT], cmd_q[0][CMD_MEM_BIT]})
    else $error("memory enables not tied to command bit 1");

  a_fixed_enables: assert property (
    !o_write_invalidate_enable && !o_back_to_back_enable)
    else $error("unsupported enable driven");

  a_serr_enable_gate: assert property (
    o_serr_oe
    |-> $past(sys_err_eff))
    else $error("SERR driven while its driver is disabled");

  a_serr_pin_level: assert property (
    o_serr_n == !o_serr_oe)
    else $error("SERR level and enable disagree");

  a_perr_pin_level: assert property (
    o_perr_n == !o_perr_oe)
    else $error("PERR level and enable disagree");

  a_perr_on_data: assert property (
    (parity_eff && (|i_data_parity_error_detected))
    |=> (o_perr_oe && !o_perr_n))
    else $error("PERR not driven on enabled data parity error");

  a_parity_ignored: assert property (
    !parity_eff
    |=> (!o_perr_oe && !o_serr_oe))
    else $error("parity error reported with response disabled");

  a_sig_sys_err: assert property (
    serr_fire
    |=> stat_w[0][STAT_SIG_SYS_ERR_BIT] && stat_w[1][STAT_SIG_SYS_ERR_BIT])
    else $error("signalled system error not recorded");

  a_data_par_set: assert property (
    i_data_parity_error_detected[0]
    |=> stat_w[0][STAT_PARITY_DET_BIT])
    else $error("data parity error not recorded");

  a_data_par_own: assert property (
    $rose(stat_w[1][STAT_PARITY_DET_BIT])
    |-> $past(i_addr_parity_error_detected || i_data_parity_error_detected[1]))
    else $error("parity flag set by the other function");

  a_master_par_f1: assert property (
    (i_perr_as_master[1] && parity_eff && o_bus_master_enable[1])
    |=> stat_w[1][STAT_MASTER_PARITY_BIT])
    else $error("master parity error not recorded");

  a_abort_status_f0: assert property (
    (i_master_abort[0] && o_bus_master_enable[0])
    |=> stat_w[0][STAT_MASTER_ABORT_BIT])
    else $error("master abort not recorded");

  a_abort_gated: assert property (
    $rose(stat_w[1][STAT_MASTER_ABORT_BIT])
    |-> $past(i_master_abort[1] && o_bus_master_enable[1]))
    else $error("master abort flag set without mastering");

  a_tabort_gate: assert property (
    $rose(stat_w[0][STAT_TABORT_RCVD_BIT])
    |-> $past(i_target_abort_rcvd[0] && o_bus_master_enable[0]))
    else $error("received target abort set without mastering");

  a_tabort_sig_own: assert property (
    i_target_abort_sig[1]
    |=> stat_w[1][STAT_TABORT_SIG_BIT])
    else $error("signalled target abort not recorded");

  a_speed_fixed_f1: assert property (
    (stat_w[1][STAT_SPEED_LSB +: 2] == STAT_SPEED_MEDIUM) && stat_w[0][STAT_CAP_LIST_BIT])
    else $error("fixed status bits wrong");

  a_stat_reserved: assert property (
    ((stat_w[0] | stat_w[1]) & ~(STAT_CLEAR_MASK | STAT_FIXED)) == 16'h0000)
    else $error("read-only status bits not at their fixed value");

  a_cmd_byte_skip: assert property (
    (cmd_wr[0] && !i_cfg_be[0] && !i_cfg_be[1])
    |=> $stable(cmd_q[0]))
    else $error("command changed by a write without its bytes");

  c_serr_report: cover property (i_addr_parity_error_detected && sys_err_eff && parity_eff ##1 o_serr_oe);
  c_status_clear: cover property (stat_w[0][STAT_MASTER_ABORT_BIT] ##1 stat_clr[0][STAT_MASTER_ABORT_BIT]
    ##1 !stat_w[0][STAT_MASTER_ABORT_BIT]);
  c_both_masters: cover property (o_bus_master_enable == 2'h3);
  c_set_and_clear: cover property (stat_set[1][STAT_PARITY_DET_BIT] && stat_clr[1][STAT_PARITY_DET_BIT]);
  c_abort_f1: cover property (stat_w[1][STAT_MASTER_ABORT_BIT] && o_bus_master_enable[1]);
endmodule // cmd_status_regs
`default_nettype wire

//--- host_cfg_model.sv
// Host side model issuing configuration reads and writes
`default_nettype none
module host_cfg_model (
  input wire logic i_clk_sys,
  input wire logic [cmd_status_pkg::DATA_W-1:0] i_cfg_rdata,
  input wire logic i_cfg_rvalid,
  output logic o_cfg_func,
  output logic o_cfg_wr,
  output logic o_cfg_rd,
  output logic [cmd_status_pkg::ADDR_W-1:0] o_cfg_addr,
  output logic [3:0] o_cfg_be,
  output logic [cmd_status_pkg::DATA_W-1:0] o_cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmd_status_pkg::*;
  initial begin
    {o_cfg_func, o_cfg_wr, o_cfg_rd, o_cfg_be} = '0;
    o_cfg_addr = 8'hFF;
    o_cfg_wdata = 32'h0;
  end
  // Called at a falling edge; holds the request over one rising edge
  task automatic put(input logic f, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d, input logic w);
    {o_cfg_func, o_cfg_addr, o_cfg_be, o_cfg_wdata} = {f, a, b, d};
    o_cfg_wr = w;
    o_cfg_rd = !w;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    {o_cfg_wr, o_cfg_rd} = 2'h0;
    // Released lines flip so stale values never look valid
    {o_cfg_addr, o_cfg_be, o_cfg_wdata} = ~{a, b, d};
  endtask
  task automatic write(input logic f, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    put(f, a, b, d, 1'b1);
    // Idle cycle so the next request is not raised in the same step
    @(negedge i_clk_sys);
  endtask
  task automatic read(input logic f, input logic [7:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = 32'h0;
    put(f, a, 4'hF, 32'h0, 1'b0);
    for (int n = 0; n < 4 && !ok; n++) begin
      if (i_cfg_rvalid === 1'b1) begin
        d = i_cfg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge i_clk_sys);
      end
    end
    @(negedge i_clk_sys);
  endtask
endmodule // host_cfg_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the two-function command and status registers
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmd_status_pkg::*;
  logic i_clk_sys, i_rst, i_cfg_func, i_cfg_wr, i_cfg_rd, o_cfg_rvalid, i_addr_parity_error_detected;
  logic [ADDR_W-1:0] i_cfg_addr;
  logic [3:0] i_cfg_be;
  logic [DATA_W-1:0] i_cfg_wdata, o_cfg_rdata;
  logic [NUM_FUNC-1:0] i_data_parity_error_detected, i_perr_as_master, i_master_abort, i_target_abort_rcvd, i_target_abort_sig;
  logic [NUM_FUNC-1:0] o_io_enable, o_mem_enable, o_bus_master_enable;
  logic o_parity_response_enable, o_system_error_enable, o_write_invalidate_enable, o_back_to_back_enable;
  logic o_perr_n, o_perr_oe, o_serr_n, o_serr_oe;
  int num_errors, samples_checked;
  cmd_status_regs i_cmd_status_regs (.i_clk_sys, .i_rst, .i_cfg_func, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
    .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .i_addr_parity_error_detected, .i_data_parity_error_detected, .i_perr_as_master,
    .i_master_abort, .i_target_abort_rcvd, .i_target_abort_sig, .o_io_enable, .o_mem_enable,
    .o_bus_master_enable, .o_parity_response_enable, .o_system_error_enable, .o_write_invalidate_enable,
    .o_back_to_back_enable, .o_perr_n, .o_perr_oe, .o_serr_n, .o_serr_oe);
  host_cfg_model i_host_cfg_model (.i_clk_sys, .i_cfg_rdata(o_cfg_rdata), .i_cfg_rvalid(o_cfg_rvalid),
    .o_cfg_func(i_cfg_func), .o_cfg_wr(i_cfg_wr), .o_cfg_rd(i_cfg_rd), .o_cfg_addr(i_cfg_addr),
    .o_cfg_be(i_cfg_be), .o_cfg_wdata(i_cfg_wdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    i_host_cfg_model.read(f, a, d, ok);
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: no read answer", $time);
      final_report();
    end
    chk(d, exp, "read data");
  endtask
  task automatic wr(input logic f, input logic [3:0] b, input logic [31:0] d);
    i_host_cfg_model.write(f, CMD_OFFSET, b, d);
  endtask
  // Events are applied for one cycle; returns when one-cycle pin pulses are visible
  task automatic pulse(input logic ap, input logic [1:0] dp, pm, ma, tr, ts);
    {i_addr_parity_error_detected, i_data_parity_error_detected, i_perr_as_master, i_master_abort, i_target_abort_rcvd, i_target_abort_sig}
      = {ap, dp, pm, ma, tr, ts};
    @(negedge i_clk_sys);
    {i_addr_parity_error_detected, i_data_parity_error_detected, i_perr_as_master, i_master_abort, i_target_abort_rcvd, i_target_abort_sig}
      = '0;
  endtask
  task automatic t_reset();
    i_rst = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    i_rst = 1'b0;
    rd(0, CMD_OFFSET, {STAT_FIXED, CMD_RESET});
    rd(1, CMD_OFFSET, {STAT_FIXED, CMD_RESET});
    chk({o_bus_master_enable, o_mem_enable, o_io_enable, o_system_error_enable}, 0, "enables");
    chk({o_serr_oe, o_serr_n, o_perr_oe, o_perr_n}, 4'h5, "pins idle");
    $display("reset test done");
  endtask
  task automatic t_cmd();
    wr(0, 4'hF, 32'h0000_FFFF);
    rd(0, CMD_OFFSET, {STAT_FIXED, 16'h0147});
    rd(1, CMD_OFFSET, {STAT_FIXED, 16'h0000});
    chk({o_bus_master_enable, o_mem_enable, o_io_enable}, 6'h15, "space enables");
    chk({o_write_invalidate_enable, o_back_to_back_enable}, 2'h0, "fixed enables");
    wr(0, 4'h2, 32'h0);
    rd(0, CMD_OFFSET, {STAT_FIXED, 16'h0047});
    i_host_cfg_model.write(0, 8'h08, 4'hF, 32'hFFFF_FFFF);
    rd(0, 8'h08, 32'h0);
    rd(0, CMD_OFFSET, {STAT_FIXED, 16'h0047});
    wr(0, 4'h3, 32'h0);
    $display("command test done");
  endtask
  task automatic t_or();
    wr(1, 4'h1, 32'h0000_0040);
    rd(0, CMD_OFFSET, {STAT_FIXED, 16'h0000});
    chk({o_system_error_enable, o_parity_response_enable}, 2'h1, "ored enables");
    wr(0, 4'h2, 32'h0000_0100);
    chk({o_system_error_enable, o_parity_response_enable}, 2'h3, "ored enables");
    rd(1, CMD_OFFSET, {STAT_FIXED, 16'h0040});
    $display("enable test done");
  endtask
  task automatic t_parity();
    pulse(1, 0, 0, 0, 0, 0);
    chk({o_serr_oe, o_serr_n}, 2'h2, "serr fires");
    @(negedge i_clk_sys);
    chk(o_serr_oe, 0, "serr one cycle");
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'hC000, 16'h0100});
    rd(1, CMD_OFFSET, {STAT_FIXED | 16'hC000, 16'h0040});
    wr(0, 4'h8, 32'h8000_0000);
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'h4000, 16'h0100});
    pulse(0, 2'h1, 0, 0, 0, 0);
    chk({o_perr_oe, o_perr_n}, 2'h2, "perr fires");
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'hC000, 16'h0100});
    wr(1, 4'hD, 32'hFFFF_0000);
    pulse(1, 2'h2, 0, 0, 0, 0);
    chk({o_serr_oe, o_perr_oe}, 2'h0, "parity ignored");
    @(negedge i_clk_sys);
    chk({o_serr_oe, o_perr_oe}, 2'h0, "parity ignored");
    rd(1, CMD_OFFSET, {STAT_FIXED | 16'h8000, 16'h0000});
    $display("parity test done");
  endtask
  task automatic t_abort();
    wr(0, 4'hF, 32'hFFFF_0004);
    pulse(0, 0, 0, 2'h3, 2'h1, 2'h2);
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'h3000, 16'h0004});
    rd(1, CMD_OFFSET, {STAT_FIXED | 16'h8800, 16'h0000});
    fork
      wr(0, 4'h8, 32'h2000_0000);
      pulse(0, 0, 0, 2'h1, 0, 0);
    join
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'h3000, 16'h0004});
    wr(0, 4'h8, 32'h3000_0000);
    rd(0, CMD_OFFSET, {STAT_FIXED, 16'h0004});
    wr(1, 4'h1, 32'h0000_0044);
    chk(o_bus_master_enable, 2'h3, "both masters");
    pulse(0, 0, 2'h3, 2'h2, 0, 0);
    rd(0, CMD_OFFSET, {STAT_FIXED | 16'h0100, 16'h0004});
    rd(1, CMD_OFFSET, {STAT_FIXED | 16'hA900, 16'h0044});
    $display("abort test done");
  endtask
  initial begin
    i_rst = 1'b1;
    {i_addr_parity_error_detected, i_data_parity_error_detected, i_perr_as_master, i_master_abort, i_target_abort_rcvd, i_target_abort_sig}
      = '0;
    num_errors = 0;
    samples_checked = 0;
    @(negedge i_clk_sys);
    t_reset();
    t_cmd();
    t_or();
    t_parity();
    t_abort();
    t_reset();
    final_report();
  end
endmodule // testbench
`default_nettype wire
